// *** logic/spsf_status_regs.sv ***
// Contract
// R01: spi master samples at bit end when sample-select set, else mid-bit
// R02: clock-edge-select set launches data on active-to-idle edge
// R03: data-or-address flag: last i2c byte was data (1) or address
// R04: stop-seen set by last stop; zero at reset or port disabled
// R05: start-seen set by last start; zero at reset or port disabled
// R06: direction flag holds r/w of last match until start, stop, nack
// R07: 10-bit mode sets address-update flag when address needs rewrite
// R08: buffer-full: received byte waiting or i2c transmit in progress
// R09: slave address write clears the address-update flag
// R10: an i2c start condition sets the start-seen flag
// R11: reading the data buffer clears the buffer-full flag
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module spsf_status_regs
    import spsf_pkg::*;
(
    // clock and reset
    input  logic              mclk,
    input  logic              rst_n,
    // write channels
    input  logic [REG_AW-1:0] s_axi_awaddr,
    input  logic              s_axi_awvalid,
    output logic              s_axi_awready,
    input  logic [31:0]       s_axi_wdata,
    input  logic [3:0]        s_axi_wstrb,
    input  logic              s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  logic              s_axi_bready,
    // read channels
    input  logic [REG_AW-1:0] s_axi_araddr,
    input  logic              s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  logic              s_axi_rready,
    // spi strobes
    input  logic              spi_bit_mid,
    input  logic              spi_bit_end,
    input  logic              sclk_to_idle,
    input  logic              sclk_to_active,
    input  logic              spi_byte_done,
    input  logic [7:0]        spi_rx_byte,
    // i2c strobes
    input  logic              i2c_start,
    input  logic              i2c_stop,
    input  logic              i2c_nack,
    input  logic              i2c_byte_done,
    input  logic [7:0]        i2c_rx_byte,
    input  logic              i2c_tx_begin,
    input  logic              i2c_tx_end,
    // engine controls
    output logic              port_enable,
    output logic              i2c_mode,
    output logic              ten_bit_mode,
    output logic              spi_master,
    output logic              input_sample_select,
    output logic              clock_edge_select,
    output logic              spi_sample,
    output logic              spi_launch,
    output logic              i2c_ack_en,
    output logic              i2c_hold_scl,
    output logic              addr_match,
    output logic [7:0]        tx_data,
    output logic              tx_load,
    // interrupt
    output logic              irq
);
    spsf_reg_if regs ();

    spsf_axil_slave u_axil (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regs          (regs)
    );

    logic [CTRL_W-1:0] ctrl;
    logic [7:0]        slave_addr;
    logic [7:0]        rx_buf;
    logic              rx_full;
    logic              tx_busy;
    logic              data_not_addr;
    logic              stop_seen;
    logic              start_seen;
    logic              rw_flag;
    logic              address_update_flag;
    logic              buffer_full_flag;
    logic              ten_ok;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_evt;
    logic [7:0]        status;
    spsf_addr_state_t  state;
    spsf_addr_state_t  next_state;

    logic i2c_on;
    logic spi_on;
    logic wr_lo;
    logic addr_wr;
    logic data_rd;
    logic hi_ok;
    logic i2c_store;
    logic spi_store;
    logic ua_set;
    logic rw_load;
    logic rw_val;
    logic is_addr;

    assign port_enable  = ctrl[CTRL_EN_BIT];
    assign i2c_mode     = ctrl[CTRL_I2C_BIT];
    assign ten_bit_mode = ctrl[CTRL_TEN_BIT];
    assign spi_master   = ctrl[CTRL_MST_BIT];
    assign i2c_on       = port_enable && i2c_mode;
    assign spi_on       = port_enable && !i2c_mode;

    assign wr_lo   = regs.wr && regs.wstrb[0];
    assign addr_wr = wr_lo && (regs.waddr == OFS_ADDR);
    assign data_rd = regs.rd && (regs.raddr == OFS_DATA);

    // end-of-bit sampling only in master mode
    assign spi_sample = spi_on && ((input_sample_select && spi_master)
                        ? spi_bit_end : spi_bit_mid);               // [R01]
    assign spi_launch = spi_on && (clock_edge_select
                        ? sclk_to_idle : sclk_to_active);           // [R02]

    // a full buffer answers with a not-acknowledge
    assign i2c_ack_en   = !rx_full;
    assign i2c_hold_scl = i2c_on && address_update_flag;

    // byte waiting, or i2c byte going out
    assign buffer_full_flag = rx_full || (i2c_on && tx_busy);       // [R08]

    assign status = {input_sample_select, clock_edge_select,
                     data_not_addr, stop_seen, start_seen,
                     rw_flag, address_update_flag, buffer_full_flag};

    // i2c slave address tracking
    always_comb begin
        next_state = state;
        i2c_store  = 1'b0;
        ua_set     = 1'b0;
        rw_load    = 1'b0;
        rw_val     = 1'b0;
        is_addr    = 1'b1;
        hi_ok      = (i2c_rx_byte[7:3] == TEN_HI_PREFIX)
                     && (i2c_rx_byte[2:1] == slave_addr[2:1]);
        if (!i2c_on || i2c_stop) begin
            next_state = SA_IDLE;
        end else if (i2c_start) begin
            next_state = SA_FIRST;
        end else if (i2c_byte_done) begin
            unique case (state)
                SA_IDLE: begin
                    next_state = SA_IDLE;
                end
                SA_FIRST: begin
                    if (!ten_bit_mode) begin
                        if (i2c_rx_byte[7:1] == slave_addr[7:1]) begin
                            next_state = SA_DATA;
                            i2c_store  = 1'b1;
                            rw_load    = 1'b1;
                            rw_val     = i2c_rx_byte[0];
                        end else begin
                            next_state = SA_IDLE;
                        end
                    end else if (hi_ok && !i2c_rx_byte[0]) begin
                        next_state = SA_LOW;
                        i2c_store  = 1'b1;
                        ua_set     = 1'b1;                          // [R07]
                    end else if (hi_ok && ten_ok) begin
                        next_state = SA_DATA;
                        i2c_store  = 1'b1;
                        rw_load    = 1'b1;
                        rw_val     = 1'b1;
                    end else begin
                        next_state = SA_IDLE;
                    end
                end
                SA_LOW: begin
                    // address must go back to the high byte either way
                    ua_set = 1'b1;                                  // [R07]
                    if (i2c_rx_byte == slave_addr) begin
                        next_state = SA_DATA;
                        i2c_store  = 1'b1;
                        rw_load    = 1'b1;
                    end else begin
                        next_state = SA_IDLE;
                    end
                end
                SA_DATA: begin
                    i2c_store = !rw_flag;
                    is_addr   = 1'b0;
                end
            endcase
        end
    end

    assign spi_store = spi_on && spi_byte_done;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state  <= SA_IDLE;
            ten_ok <= 1'b0;
        end else begin
            state <= next_state;
            if (!i2c_on || i2c_stop) begin
                ten_ok <= 1'b0;
            end else if (state == SA_LOW && next_state == SA_DATA) begin
                ten_ok <= 1'b1;
            end
        end
    end

    // software settings
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            input_sample_select <= STATUS_RST[ST_SMP_BIT];
            clock_edge_select   <= STATUS_RST[ST_CKE_BIT];
            ctrl                <= CTRL_RST;
            slave_addr          <= ADDR_RST;
            irq_mask            <= IRQ_RST;
        end else if (wr_lo) begin
            unique case (regs.waddr)
                OFS_STATUS: begin
                    input_sample_select <= regs.wdata[ST_SMP_BIT];
                    clock_edge_select   <= regs.wdata[ST_CKE_BIT];
                end
                OFS_CTRL:     ctrl       <= regs.wdata[CTRL_W-1:0];
                OFS_ADDR:     slave_addr <= regs.wdata[7:0];
                OFS_IRQ_MASK: irq_mask   <= regs.wdata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data <= 8'h00;
            tx_load <= 1'b0;
        end else begin
            tx_load <= wr_lo && (regs.waddr == OFS_DATA);
            if (wr_lo && regs.waddr == OFS_DATA) begin
                tx_data <= regs.wdata[7:0];
            end
        end
    end

    // last bus condition seen
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
        end else if (!port_enable) begin
            start_seen <= 1'b0;                                     // [R05]
            stop_seen  <= 1'b0;                                     // [R04]
        end else if (i2c_on && i2c_start) begin
            start_seen <= 1'b1;                                     // [R10]
            stop_seen  <= 1'b0;                                     // [R04]
        end else if (i2c_on && i2c_stop) begin
            start_seen <= 1'b0;                                     // [R05]
            stop_seen  <= 1'b1;                                     // [R04]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rw_flag <= 1'b0;
        end else if (!i2c_on || i2c_start || i2c_stop || i2c_nack) begin
            rw_flag <= 1'b0;                                        // [R06]
        end else if (rw_load) begin
            rw_flag <= rw_val;                                      // [R06]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_not_addr <= 1'b0;
        end else if (i2c_on && i2c_byte_done && state != SA_IDLE) begin
            data_not_addr <= !is_addr;                              // [R03]
        end else if (i2c_on && i2c_tx_begin && state == SA_DATA) begin
            data_not_addr <= 1'b1;                                  // [R03]
        end
    end

    // set wins over an address write in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            address_update_flag <= 1'b0;
        end else if (!i2c_on || !ten_bit_mode) begin
            address_update_flag <= 1'b0;
        end else if (ua_set) begin
            address_update_flag <= 1'b1;                            // [R07]
        end else if (addr_wr) begin
            address_update_flag <= 1'b0;                            // [R09]
        end
    end

    // overrun keeps the held byte; a read in the same cycle makes room
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_full <= 1'b0;
            rx_buf  <= 8'h00;
        end else if ((i2c_store || spi_store) && (!rx_full || data_rd)) begin
            rx_full <= 1'b1;                                        // [R08]
            rx_buf  <= i2c_store ? i2c_rx_byte : spi_rx_byte;
        end else if (data_rd) begin
            rx_full <= 1'b0;                                        // [R11]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy <= 1'b0;
        end else if (!i2c_on || i2c_tx_end) begin
            tx_busy <= 1'b0;                                        // [R08]
        end else if (i2c_tx_begin) begin
            tx_busy <= 1'b1;                                        // [R08]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_match <= 1'b0;
        end else begin
            addr_match <= rw_load;
        end
    end

    // sticky status, write one to clear, events win
    always_comb begin
        irq_evt                = '0;
        irq_evt[IRQ_START_BIT] = i2c_on && i2c_start;
        irq_evt[IRQ_STOP_BIT]  = i2c_on && i2c_stop;
        irq_evt[IRQ_BYTE_BIT]  = (i2c_store || spi_store)
                                 && (!rx_full || data_rd);
        irq_evt[IRQ_UA_BIT]    = ua_set;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= IRQ_RST;
        end else if (wr_lo && regs.waddr == OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~regs.wdata[IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_stat <= irq_stat | irq_evt;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // read mux
    always_comb begin
        regs.rdata = '0;
        regs.rhit  = 1'b1;
        unique case (regs.raddr)
            OFS_STATUS:   regs.rdata[7:0]        = status;
            OFS_ADDR:     regs.rdata[7:0]        = slave_addr;
            OFS_DATA:     regs.rdata[7:0]        = rx_buf;
            OFS_CTRL:     regs.rdata[CTRL_W-1:0] = ctrl;
            OFS_IRQ_STAT: regs.rdata[IRQ_W-1:0]  = irq_stat;
            OFS_IRQ_MASK: regs.rdata[IRQ_W-1:0]  = irq_mask;
            default:      regs.rhit              = 1'b0;
        endcase
    end

    always_comb begin
        unique case (regs.waddr)
            OFS_STATUS, OFS_ADDR, OFS_DATA,
            OFS_CTRL, OFS_IRQ_STAT, OFS_IRQ_MASK: regs.whit = 1'b1;
            default:                              regs.whit = 1'b0;
        endcase
    end
endmodule : spsf_status_regs

// *** logic/spsf_pkg.sv ***
package spsf_pkg;
    // register bus
    localparam int         REG_AW      = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register offsets
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_ADDR     = 8'h04;
    localparam logic [7:0] OFS_DATA     = 8'h08;
    localparam logic [7:0] OFS_CTRL     = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // status fields
    localparam int ST_SMP_BIT = 7;
    localparam int ST_CKE_BIT = 6;
    localparam int ST_DA_BIT  = 5;
    localparam int ST_P_BIT   = 4;
    localparam int ST_S_BIT   = 3;
    localparam int ST_RW_BIT  = 2;
    localparam int ST_UA_BIT  = 1;
    localparam int ST_BF_BIT  = 0;

    // control fields
    localparam int CTRL_W       = 4;
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_I2C_BIT = 1;
    localparam int CTRL_TEN_BIT = 2;
    localparam int CTRL_MST_BIT = 3;

    // interrupt fields
    localparam int IRQ_W         = 4;
    localparam int IRQ_START_BIT = 0;
    localparam int IRQ_STOP_BIT  = 1;
    localparam int IRQ_BYTE_BIT  = 2;
    localparam int IRQ_UA_BIT    = 3;

    // values after reset
    localparam logic [7:0]        STATUS_RST = 8'h00;
    localparam logic [7:0]        ADDR_RST   = 8'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
    localparam logic [IRQ_W-1:0]  IRQ_RST    = 4'h0;

    // prefix of a 10-bit high address byte
    localparam logic [4:0] TEN_HI_PREFIX = 5'h1E;

    typedef enum logic [1:0] {
        SA_IDLE,
        SA_FIRST,
        SA_LOW,
        SA_DATA
    } spsf_addr_state_t;
endpackage : spsf_pkg

// *** logic/spsf_reg_if.sv ***
`timescale 1ns/1ns
interface spsf_reg_if
    import spsf_pkg::*;
;
    logic              wr;
    logic [REG_AW-1:0] waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              whit;
    logic              rd;
    logic [REG_AW-1:0] raddr;
    logic [31:0]       rdata;
    logic              rhit;

    modport bus  (output wr, waddr, wdata, wstrb, rd, raddr,
                  input  whit, rdata, rhit);
    modport regs (input  wr, waddr, wdata, wstrb, rd, raddr,
                  output whit, rdata, rhit);
endinterface : spsf_reg_if

// *** logic/spsf_axil_slave.sv ***
`timescale 1ns/1ns
module spsf_axil_slave
    import spsf_pkg::*;
(
    // clock and reset
    input  logic              mclk,
    input  logic              rst_n,
    // write channels
    input  logic [REG_AW-1:0] s_axi_awaddr,
    input  logic              s_axi_awvalid,
    output logic              s_axi_awready,
    input  logic [31:0]       s_axi_wdata,
    input  logic [3:0]        s_axi_wstrb,
    input  logic              s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  logic              s_axi_bready,
    // read channels
    input  logic [REG_AW-1:0] s_axi_araddr,
    input  logic              s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  logic              s_axi_rready,
    // register side
    spsf_reg_if.bus           regs
);
    logic              aw_held;
    logic              w_held;
    logic [REG_AW-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;

    // address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign regs.wr       = aw_held && w_held && !s_axi_bvalid;
    assign regs.waddr    = aw_addr;
    assign regs.wdata    = w_data;
    assign regs.wstrb    = w_strb;
    assign regs.rd       = s_axi_arvalid && s_axi_arready;
    assign regs.raddr    = s_axi_araddr;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (regs.wr) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (regs.wr) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (regs.wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= regs.whit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (regs.rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= regs.rdata;
            s_axi_rresp  <= regs.rhit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : spsf_axil_slave

// *** testbench/spsf_engine_model.sv ***
`timescale 1ns/1ns
module spsf_engine_model (
    // strobe timing
    input  logic        mclk,
    // strobes and received byte
    output logic [10:0] ev,
    output logic [7:0]  rx_byte
);
    initial {ev, rx_byte} = 19'h0_00A5;
    // one-cycle strobe; byte lines flip once the strobe is gone
    task automatic send(input int k, input logic [7:0] b);
        @(posedge mclk);
        ev <= 11'h001 << k;
        rx_byte <= b;
        @(posedge mclk);
        ev <= 11'h000;
        rx_byte <= ~b;
    endtask : send
endmodule : spsf_engine_model

// *** testbench/spsf_status_props.sv ***
`timescale 1ns/1ns
module spsf_status_props
    import spsf_pkg::*;
(
    // clock, reset and bus
    input logic mclk, rst_n, s_axi_arvalid, s_axi_arready,
    input logic s_axi_rvalid, s_axi_bvalid,
    input logic [REG_AW-1:0] s_axi_araddr,
    // modes and strobes
    input logic port_enable, i2c_mode, ten_bit_mode, spi_master,
    input logic input_sample_select, clock_edge_select, spi_bit_mid,
    input logic spi_bit_end, sclk_to_idle, sclk_to_active, spi_byte_done,
    input logic i2c_byte_done, spi_sample, spi_launch, i2c_ack_en,
    input logic i2c_hold_scl, addr_match
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_sample_point:
        assert property (spi_sample == (port_enable && !i2c_mode &&
            (input_sample_select && spi_master ? spi_bit_end : spi_bit_mid)))
        else $error("bad sample");
    a_launch_edge:
        assert property (spi_launch == (port_enable && !i2c_mode &&
            (clock_edge_select ? sclk_to_idle : sclk_to_active)))
        else $error("bad launch");
    a_hold_mode:
        assert property (i2c_hold_scl |-> port_enable && ten_bit_mode)
        else $error("bad hold");
    a_ua_clear:
        assert property ($fell(i2c_hold_scl) && port_enable && i2c_mode &&
            ten_bit_mode |-> $rose(s_axi_bvalid))
        else $error("bad ua clear");
    a_bf_set:
        assert property (spi_byte_done && port_enable && !i2c_mode
            |=> !i2c_ack_en)
        else $error("bf not set");
    a_bf_clear:
        assert property ($rose(i2c_ack_en) && port_enable &&
            $past(port_enable) |-> $past(s_axi_arvalid && s_axi_arready &&
            s_axi_araddr == OFS_DATA))
        else $error("bad bf clear");
    a_match_pulse:
        assert property (addr_match |-> $past(i2c_byte_done) &&
            !$past(addr_match))
        else $error("bad match");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no rvalid");
endmodule : spsf_status_props
bind spsf_status_regs spsf_status_props u_props (.*);

// *** testbench/test_serial_port_status_flags.sv ***
`timescale 1ns/1ns
module test_serial_port_status_flags
    import spsf_pkg::*;
;
    logic mclk, rst_n, irq, tx_load, spi_sample, spi_launch, addr_match;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, port_enable, i2c_mode, ten_bit_mode;
    logic spi_master, input_sample_select, clock_edge_select, i2c_ack_en;
    logic i2c_hold_scl, spi_bit_mid, spi_bit_end, sclk_to_idle;
    logic sclk_to_active, spi_byte_done, i2c_start, i2c_stop, i2c_nack;
    logic i2c_byte_done, i2c_tx_begin, i2c_tx_end;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, spi_rx_byte, i2c_rx_byte;
    logic [7:0]  tx_data, rxb, sb, a, b;
    logic [10:0] ev;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    int          num_errors = 0;
    int          total_checks = 0;
    logic [7:0]  rxq[$];
    spsf_status_regs u_dut (.*);
    spsf_engine_model u_eng (.mclk(mclk), .ev(ev), .rx_byte(rxb));
    assign {i2c_tx_end, i2c_tx_begin, i2c_byte_done, i2c_nack, i2c_stop,
            i2c_start, spi_byte_done, sclk_to_active, sclk_to_idle,
            spi_bit_end, spi_bit_mid} = ev;
    assign spi_rx_byte = rxb;
    assign i2c_rx_byte = rxb;
    always #50 mclk = ~mclk;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] ad, m, e, input string n);
        @(posedge mclk);
        s_axi_araddr <= ad;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(n, 32'(s_axi_rdata[7:0] & m), 32'(e));
    endtask : rc
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        finish_test();
    end
    initial begin
        {mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        seed = 32'h0000_48C6;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rc(OFS_STATUS, 8'hFF, 8'h00, "reset");
        wr(OFS_STATUS, xs());
        sb = seed[7:0] & 8'hC0;
        rc(OFS_STATUS, 8'hFF, sb, "config");
        wr(OFS_IRQ_MASK, 32'h0000_000F);
        wr(OFS_CTRL, 32'h0000_0009);
        b = 8'(xs());
        for (int k = 0; k < 5; k++) u_eng.send(k, b);
        rxq.push_back(b);
        rc(OFS_STATUS, 8'hFF, sb | 8'h01, "spi full");
        rc(OFS_DATA, 8'hFF, rxq.pop_front(), "spi data");
        rc(OFS_STATUS, 8'hFF, sb, "spi empty");
        a = 8'(xs()) & 8'hFE;
        wr(OFS_ADDR, 32'(a));
        wr(OFS_CTRL, 32'h0000_0003);
        u_eng.send(5, 8'h00);
        rc(OFS_STATUS, 8'h3F, 8'h08, "start");
        chk("irq start", 32'(irq), 32'h1);
        u_eng.send(8, a);
        rc(OFS_STATUS, 8'h3F, 8'h09, "addr");
        rc(OFS_DATA, 8'hFF, a, "addr rd");
        rxq.push_back(8'(xs()));
        u_eng.send(8, rxq[0]);
        rc(OFS_STATUS, 8'h3F, 8'h29, "data");
        rc(OFS_DATA, 8'hFF, rxq.pop_front(), "data rd");
        u_eng.send(6, 8'h00);
        rc(OFS_STATUS, 8'h1F, 8'h10, "stop");
        wr(OFS_IRQ_STAT, 32'h0000_000F);
        chk("irq clr", 32'(irq), 32'h0);
        u_eng.send(5, 8'h00);
        u_eng.send(8, a | 8'h01);
        rc(OFS_STATUS, 8'h1F, 8'h0D, "rd req");
        rc(OFS_DATA, 8'hFF, a | 8'h01, "req rd");
        u_eng.send(9, 8'h00);
        rc(OFS_STATUS, 8'h21, 8'h21, "tx busy");
        u_eng.send(10, 8'h00);
        u_eng.send(7, 8'h00);
        rc(OFS_STATUS, 8'h05, 8'h00, "nack");
        wr(OFS_CTRL, 32'h0000_0000);
        rc(OFS_STATUS, 8'h18, 8'h00, "off");
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        a = {TEN_HI_PREFIX, 2'(xs()), 1'b0};
        wr(OFS_ADDR, 32'(a));
        wr(OFS_CTRL, 32'h0000_0007);
        u_eng.send(5, 8'h00);
        u_eng.send(8, a);
        rc(OFS_STATUS, 8'h1F, 8'h0B, "high");
        chk("irq masked", 32'(irq), 32'h0);
        wr(OFS_ADDR, 32'h0000_0055);
        rc(OFS_STATUS, 8'h02, 8'h00, "addr rewrite");
        rc(8'h40, 8'hFF, 8'h00, "unmapped");
        chk("bad resp", 32'(rsp), 32'(RESP_SLVERR));
        finish_test();
    end
endmodule : test_serial_port_status_flags
